/* verilog/pcs_phy_port.sv */
// Physical-side port of the PCS: transceiver character path and ten-bit interface
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_phy_port
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clk_locked,
    input wire logic soft_reset,
    input wire logic loss_of_sync,
    input wire logic power_down_req,
    input wire logic [`PCS_CHAR_W-1:0] tx_char,
    input wire logic tx_is_ctrl,
    input wire logic tx_disp_force,
    input wire logic tx_disp_value,
    input wire logic [`PCS_SYM_W-1:0] tx_symbol,
    input wire logic loopback_req,
    input wire logic [`PCS_CHAR_W-1:0] xcvr_rx_char,
    input wire logic xcvr_rx_is_ctrl,
    input wire logic xcvr_rx_is_comma,
    input wire logic xcvr_rx_disp_err,
    input wire logic xcvr_rx_not_in_table,
    input wire logic xcvr_rx_run_disp,
    input wire logic [`PCS_BUFST_W-1:0] xcvr_rx_buf_state,
    input wire logic [`PCS_CCNT_W-1:0] xcvr_rx_clk_cor_cnt,
    input wire logic xcvr_tx_buf_err,
    output logic xcvr_rx_reset,
    output logic xcvr_tx_reset,
    output logic xcvr_power_down,
    output logic [`PCS_CHAR_W-1:0] xcvr_tx_char,
    output logic xcvr_tx_is_ctrl,
    output logic xcvr_tx_disp_mode,
    output logic xcvr_tx_disp_val,
    output logic plus_comma_align_en,
    output logic minus_comma_align_en,
    output logic [`PCS_CHAR_W-1:0] rx_char,
    output logic rx_is_ctrl,
    output logic rx_is_comma,
    output logic rx_disp_err,
    output logic rx_not_in_table,
    output logic rx_run_disp,
    output logic [`PCS_BUFST_W-1:0] rx_buf_state,
    output logic [`PCS_CCNT_W-1:0] rx_clk_cor_cnt,
    output logic [`PCS_SYM_W-1:0] tbi_tx_symbol,
    output logic tbi_lock_ref,
    output logic tbi_loopback,
    output logic tbi_comma_detect_en,
    input wire logic tbi_rx_clk_a,
    input wire logic tbi_rx_clk_b,
    input wire logic [`PCS_SYM_W-1:0] tbi_rx_symbol_even,
    input wire logic [`PCS_SYM_W-1:0] tbi_rx_symbol_odd,
    output logic rx_sym_valid,
    output logic [`PCS_SYM_W-1:0] rx_sym_data,
    input wire logic rx_sym_ready,
    output logic rx_sym_overrun
);

    pcs_top_st_t st;
    pcs_top_st_t next_st;
    pcs_stream_if buf_in ();
    pcs_stream_if buf_out ();

    // Falling edge of a synchronised receive clock
    function automatic logic fall_edge(input logic now, input logic prev);
        fall_edge = prev && !now;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // Lock level and receive clocks pass two flops before use
        next_st.lock_s1 = clk_locked;
        next_st.lock_s2 = st.lock_s1;
        next_st.ca_s1 = tbi_rx_clk_a;
        next_st.ca_s2 = st.ca_s1;
        next_st.ca_s3 = st.ca_s2;
        next_st.cb_s1 = tbi_rx_clk_b;
        next_st.cb_s2 = st.cb_s1;
        next_st.cb_s3 = st.cb_s2;
        next_st.sa_s1 = tbi_rx_symbol_even;
        next_st.sa_s2 = st.sa_s1;
        next_st.sb_s1 = tbi_rx_symbol_odd;
        next_st.sb_s2 = st.sb_s1;

        // Symbols change on rising edges, so the copy taken at a falling edge is settled
        next_st.overrun = st.push && !buf_in.ready;
        if (st.push && !buf_in.ready) begin
            next_st.push = 1'b0;
        end else if (st.push) begin
            next_st.push = 1'b0;
        end
        if (fall_edge(st.ca_s2, st.ca_s3) && st.phase == PH_EVEN) begin
            next_st.push = 1'b1;
            next_st.push_data = st.sa_s2;
            next_st.phase = PH_ODD;
        end else if (fall_edge(st.cb_s2, st.cb_s3) && st.phase == PH_ODD) begin
            next_st.push = 1'b1;
            next_st.push_data = st.sb_s2;
            next_st.phase = PH_EVEN;
        end

        // Transceiver resets: lock and soft reset hold both; each buffer error holds only its own side
        next_st.xrx_rst = !st.lock_s2 || soft_reset || xcvr_rx_buf_state[`PCS_RXBUF_ERR_BIT];
        next_st.xtx_rst = !st.lock_s2 || soft_reset || xcvr_tx_buf_err;

        // Comma realignment follows loss of sync on both interfaces
        next_st.comma_en = loss_of_sync;
        next_st.tbi_cdet = loss_of_sync;

        // Transmit side towards the transceiver
        next_st.power_down = power_down_req;
        next_st.xtx_char = tx_char;
        next_st.xtx_ctrl = tx_is_ctrl;
        next_st.xtx_dmode = tx_disp_force;
        next_st.xtx_dval = tx_disp_value;

        // Received character path; same clock as the transceiver, so no synchroniser
        next_st.rx_char = xcvr_rx_char;
        next_st.rx_ctrl = xcvr_rx_is_ctrl;
        next_st.rx_comma = xcvr_rx_is_comma;
        next_st.rx_derr = xcvr_rx_disp_err;
        next_st.rx_nit = xcvr_rx_not_in_table;
        next_st.rx_rdisp = xcvr_rx_run_disp;
        next_st.rx_bufst = xcvr_rx_buf_state;
        next_st.rx_ccnt = xcvr_rx_clk_cor_cnt;

        // Ten-bit transmit side
        next_st.tbi_tx = tx_symbol;
        next_st.tbi_lref = `PCS_LOCK_REF_LEVEL;
        next_st.tbi_loop = loopback_req;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Resets to the transceiver start asserted; low clock enable freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.xrx_rst <= `PCS_XRST_RESET;
            st.xtx_rst <= `PCS_XRST_RESET;
            st.tbi_lref <= `PCS_LOCK_REF_LEVEL;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    // A lost word cannot be asked for again, so a full buffer is reported as overrun
    assign buf_in.valid = st.push;
    assign buf_in.data = st.push_data;
    assign buf_out.ready = rx_sym_ready;

    pcs_pair_buf u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .s_in(buf_in),
        .s_out(buf_out)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign xcvr_rx_reset = st.xrx_rst;
    assign xcvr_tx_reset = st.xtx_rst;
    assign xcvr_power_down = st.power_down;
    assign xcvr_tx_char = st.xtx_char;
    assign xcvr_tx_is_ctrl = st.xtx_ctrl;
    assign xcvr_tx_disp_mode = st.xtx_dmode;
    assign xcvr_tx_disp_val = st.xtx_dval;
    assign plus_comma_align_en = st.comma_en;
    assign minus_comma_align_en = st.comma_en;
    assign rx_char = st.rx_char;
    assign rx_is_ctrl = st.rx_ctrl;
    assign rx_is_comma = st.rx_comma;
    assign rx_disp_err = st.rx_derr;
    assign rx_not_in_table = st.rx_nit;
    assign rx_run_disp = st.rx_rdisp;
    assign rx_buf_state = st.rx_bufst;
    assign rx_clk_cor_cnt = st.rx_ccnt;
    assign tbi_tx_symbol = st.tbi_tx;
    assign tbi_lock_ref = st.tbi_lref;
    assign tbi_loopback = st.tbi_loop;
    assign tbi_comma_detect_en = st.tbi_cdet;
    assign rx_sym_valid = buf_out.valid;
    assign rx_sym_data = buf_out.data;
    assign rx_sym_overrun = st.overrun;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_lock_hold;
        (ce && !st.lock_s2) |=> (xcvr_rx_reset && xcvr_tx_reset);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("transceiver left reset without lock");

    property p_rx_rst;
        (ce && st.lock_s2 && !soft_reset) |=> (xcvr_rx_reset == $past(xcvr_rx_buf_state[`PCS_RXBUF_ERR_BIT]));
    endproperty
    a_rx_rst: assert property (p_rx_rst) else $error("rx reset does not track buffer error");

    property p_tx_rst;
        (ce && (soft_reset || xcvr_tx_buf_err)) |=> xcvr_tx_reset;
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("tx reset missing");

    property p_comma;
        ce |=> (plus_comma_align_en == $past(loss_of_sync)) && (minus_comma_align_en == plus_comma_align_en);
    endproperty
    a_comma: assert property (p_comma) else $error("comma align enable wrong");

    property p_cdet;
        (ce && loss_of_sync) ##1 (ce && !loss_of_sync) |=> !tbi_comma_detect_en;
    endproperty
    a_cdet: assert property (p_cdet) else $error("comma detect outlived loss of sync");

    property p_rx_char;
        ce |=> (rx_char == $past(xcvr_rx_char)) && (rx_clk_cor_cnt == $past(xcvr_rx_clk_cor_cnt));
    endproperty
    a_rx_char: assert property (p_rx_char) else $error("received character not passed on");

    property p_tx_sym;
        ce |=> (tbi_tx_symbol == $past(tx_symbol)) && (xcvr_tx_char == $past(tx_char));
    endproperty
    a_tx_sym: assert property (p_tx_sym) else $error("transmit symbol not one cycle late");

    property p_lref;
        !tbi_lock_ref;
    endproperty
    a_lref: assert property (p_lref) else $error("lock to reference driven high");

    property p_loop;
        ce |=> (tbi_loopback == $past(loopback_req));
    endproperty
    a_loop: assert property (p_loop) else $error("loopback request not followed");

    property p_alt;
        (st.push && st.phase == PH_ODD) |-> (st.push_data == $past(st.sa_s2));
    endproperty
    a_alt: assert property (p_alt) else $error("even symbol not taken from even bus");

endmodule

/* verilog/pcs_regs.svh */
// Constants of the physical-side port: widths, bit positions and reset values
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ----------------------------------------
// Field widths
// ----------------------------------------
`define PCS_CHAR_W 8
`define PCS_SYM_W 10
`define PCS_BUFST_W 2
`define PCS_CCNT_W 3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCS_RXBUF_ERR_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCS_XRST_RESET 1'b1
`define PCS_LOCK_REF_LEVEL 1'b0

`endif

/* verilog/pcs_pkg.sv */
// Types shared by the physical-side port and its receive buffer
`include "pcs_regs.svh"

package pcs_pkg;

    // Which half of the ten-bit receive pair is due next
    typedef enum logic {
        PH_EVEN,
        PH_ODD
    } pcs_phase_t;

    typedef logic [`PCS_SYM_W-1:0] pcs_sym_t;

    // State of the top module
    typedef struct packed {
        logic lock_s1;
        logic lock_s2;
        logic ca_s1;
        logic ca_s2;
        logic ca_s3;
        logic cb_s1;
        logic cb_s2;
        logic cb_s3;
        pcs_sym_t sa_s1;
        pcs_sym_t sa_s2;
        pcs_sym_t sb_s1;
        pcs_sym_t sb_s2;
        pcs_phase_t phase;
        logic push;
        pcs_sym_t push_data;
        logic overrun;
        logic xrx_rst;
        logic xtx_rst;
        logic comma_en;
        logic power_down;
        logic [`PCS_CHAR_W-1:0] xtx_char;
        logic xtx_ctrl;
        logic xtx_dmode;
        logic xtx_dval;
        logic [`PCS_CHAR_W-1:0] rx_char;
        logic rx_ctrl;
        logic rx_comma;
        logic rx_derr;
        logic rx_nit;
        logic rx_rdisp;
        logic [`PCS_BUFST_W-1:0] rx_bufst;
        logic [`PCS_CCNT_W-1:0] rx_ccnt;
        pcs_sym_t tbi_tx;
        logic tbi_lref;
        logic tbi_loop;
        logic tbi_cdet;
    } pcs_top_st_t;

    // State of the two-entry buffer: registered head plus one skid slot
    typedef struct packed {
        logic ov;
        pcs_sym_t od;
        logic sv;
        pcs_sym_t sd;
    } pcs_buf_st_t;

endpackage

/* verilog/pcs_stream_if.sv */
// Valid/ready carrier for received ten-bit symbols
`timescale 1ns/1ps
`include "pcs_regs.svh"

interface pcs_stream_if;
    logic valid;
    logic ready;
    logic [`PCS_SYM_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* verilog/pcs_pair_buf.sv */
// Two-entry buffer for received symbols with registered output
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_pair_buf
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    pcs_stream_if.snk s_in,
    pcs_stream_if.src s_out
);

    pcs_buf_st_t st;
    pcs_buf_st_t next_st;
    logic accept;
    logic pop;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Skid slot full means no room; ready is a flop, so no path from the sink
    always_comb begin
        next_st = st;
        accept = ce && s_in.valid && !st.sv;
        pop = ce && st.ov && s_out.ready;
        if (pop || !st.ov) begin
            if (st.sv) begin
                next_st.ov = 1'b1;
                next_st.od = st.sd;
                next_st.sv = 1'b0;
            end else begin
                next_st.ov = accept;
                if (accept) begin
                    next_st.od = s_in.data;
                end
            end
        end else if (accept) begin
            next_st.sv = 1'b1;
            next_st.sd = s_in.data;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign s_in.ready = !st.sv;
    assign s_out.valid = st.ov;
    assign s_out.data = st.od;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_buf_hold;
        @(posedge clk) disable iff (!rst_n)
        (st.ov && !s_out.ready) |=> (st.ov && $stable(st.od));
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("stalled symbol changed or vanished");

    property p_buf_order;
        @(posedge clk) disable iff (!rst_n)
        (pop && st.sv) |=> (st.ov && st.od == $past(st.sd));
    endproperty
    a_buf_order: assert property (p_buf_order) else $error("skid word not moved to head");

endmodule

/* bench/pcs_serdes_model.sv */
// Behavioural ten-bit SerDes receive side: two antiphase half-rate clocks and their symbol buses
`timescale 1ns/1ps

module pcs_serdes_model (
    output logic clk_a,
    output logic clk_b,
    output logic [9:0] sym_even,
    output logic [9:0] sym_odd
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    // Clocks stand still low between frames
    initial begin
        clk_a = 1'b0;
        clk_b = 1'b0;
        sym_even = 10'h000;
        sym_odd = 10'h000;
    end

    // ----------------------------------------
    // Frame generator
    // ----------------------------------------
    // Even word rides clk_a, odd word rides clk_b half a period later
    task automatic send(input logic [9:0] base, input int pairs);
        for (int p = 0; p < pairs; p++) begin
            sym_even = base + 10'(2 * p);
            clk_a = 1'b1;
            #80;
            clk_a = 1'b0;
            sym_odd = base + 10'(2 * p + 1);
            clk_b = 1'b1;
            #80;
            clk_b = 1'b0;
        end
        // Odd word held past its edge, then the released buses show junk
        #80;
        sym_even = ~sym_even;
        sym_odd = ~sym_odd;
    endtask
endmodule

/* bench/pcs_phy_port_bench.sv */
// Self-checking bench for the physical-side port
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_phy_port_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, clk_locked = 1'b0;
    logic soft_reset, loss_of_sync, power_down_req, tx_is_ctrl, tx_disp_force, tx_disp_value, loopback_req;
    logic [7:0] tx_char, xcvr_rx_char, xcvr_tx_char, rx_char;
    logic [9:0] tx_symbol, tbi_rx_symbol_even, tbi_rx_symbol_odd, tbi_tx_symbol, rx_sym_data;
    logic xcvr_rx_is_ctrl, xcvr_rx_is_comma, xcvr_rx_disp_err, xcvr_rx_not_in_table, xcvr_rx_run_disp;
    logic [1:0] xcvr_rx_buf_state, rx_buf_state;
    logic [2:0] xcvr_rx_clk_cor_cnt, rx_clk_cor_cnt;
    logic xcvr_tx_buf_err, xcvr_rx_reset, xcvr_tx_reset, xcvr_power_down, xcvr_tx_is_ctrl;
    logic xcvr_tx_disp_mode, xcvr_tx_disp_val, plus_comma_align_en, minus_comma_align_en;
    logic rx_is_ctrl, rx_is_comma, rx_disp_err, rx_not_in_table, rx_run_disp;
    logic tbi_lock_ref, tbi_loopback, tbi_comma_detect_en, tbi_rx_clk_a, tbi_rx_clk_b;
    logic rx_sym_valid, rx_sym_ready, rx_sym_overrun;
    logic [31:0] pat;
    logic [2:0] c;
    logic [9:0] got[$];
    int errors = 0, checks = 0, drops = 0, cycles = 0;

    pcs_phy_port i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .clk_locked(clk_locked), .soft_reset(soft_reset),
        .loss_of_sync(loss_of_sync), .power_down_req(power_down_req), .tx_char(tx_char), .tx_is_ctrl(tx_is_ctrl),
        .tx_disp_force(tx_disp_force), .tx_disp_value(tx_disp_value), .tx_symbol(tx_symbol),
        .loopback_req(loopback_req), .xcvr_rx_char(xcvr_rx_char), .xcvr_rx_is_ctrl(xcvr_rx_is_ctrl),
        .xcvr_rx_is_comma(xcvr_rx_is_comma), .xcvr_rx_disp_err(xcvr_rx_disp_err),
        .xcvr_rx_not_in_table(xcvr_rx_not_in_table), .xcvr_rx_run_disp(xcvr_rx_run_disp),
        .xcvr_rx_buf_state(xcvr_rx_buf_state), .xcvr_rx_clk_cor_cnt(xcvr_rx_clk_cor_cnt),
        .xcvr_tx_buf_err(xcvr_tx_buf_err), .xcvr_rx_reset(xcvr_rx_reset), .xcvr_tx_reset(xcvr_tx_reset),
        .xcvr_power_down(xcvr_power_down), .xcvr_tx_char(xcvr_tx_char), .xcvr_tx_is_ctrl(xcvr_tx_is_ctrl),
        .xcvr_tx_disp_mode(xcvr_tx_disp_mode), .xcvr_tx_disp_val(xcvr_tx_disp_val),
        .plus_comma_align_en(plus_comma_align_en), .minus_comma_align_en(minus_comma_align_en),
        .rx_char(rx_char), .rx_is_ctrl(rx_is_ctrl), .rx_is_comma(rx_is_comma), .rx_disp_err(rx_disp_err),
        .rx_not_in_table(rx_not_in_table), .rx_run_disp(rx_run_disp), .rx_buf_state(rx_buf_state),
        .rx_clk_cor_cnt(rx_clk_cor_cnt), .tbi_tx_symbol(tbi_tx_symbol), .tbi_lock_ref(tbi_lock_ref),
        .tbi_loopback(tbi_loopback), .tbi_comma_detect_en(tbi_comma_detect_en), .tbi_rx_clk_a(tbi_rx_clk_a),
        .tbi_rx_clk_b(tbi_rx_clk_b), .tbi_rx_symbol_even(tbi_rx_symbol_even),
        .tbi_rx_symbol_odd(tbi_rx_symbol_odd), .rx_sym_valid(rx_sym_valid), .rx_sym_data(rx_sym_data),
        .rx_sym_ready(rx_sym_ready), .rx_sym_overrun(rx_sym_overrun)
    );

    pcs_serdes_model i_serdes (
        .clk_a(tbi_rx_clk_a),
        .clk_b(tbi_rx_clk_b),
        .sym_even(tbi_rx_symbol_even),
        .sym_odd(tbi_rx_symbol_odd)
    );

    // One core clock for the whole block
    always #10 clk = ~clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Stream sink and overrun counter; timeout cuts a hang short
    always @(posedge clk) begin
        if (rx_sym_valid === 1'b1 && rx_sym_ready === 1'b1) got.push_back(rx_sym_data);
        if (rx_sym_overrun === 1'b1) drops++;
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim;
        end
    end

    // Settling wait covers the two-flop sampling of the link clocks
    // Frame starts just after a core edge so link edges never race the sampling edge
    task automatic stream(input logic [9:0] base, input int pairs);
        step;
        i_serdes.send(base, pairs);
        repeat (6) step;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {soft_reset, loss_of_sync, power_down_req, tx_char, tx_is_ctrl, tx_disp_force, tx_disp_value} <= '0;
        {tx_symbol, loopback_req, xcvr_rx_char, xcvr_rx_is_ctrl, xcvr_rx_is_comma, xcvr_rx_disp_err} <= '0;
        {xcvr_rx_not_in_table, xcvr_rx_run_disp, xcvr_rx_buf_state, xcvr_rx_clk_cor_cnt} <= '0;
        {xcvr_tx_buf_err, rx_sym_ready} <= '0;
        step;
        chk("xcvr_rx_reset", 1, xcvr_rx_reset);
        chk("rx_sym_valid", 0, rx_sym_valid);
        @(posedge clk);
        rst_n <= 1'b1;
        // Transceiver stays in reset until the clock manager locks
        repeat (5) step;
        chk("xcvr_tx_reset", 1, xcvr_tx_reset);
        @(posedge clk);
        clk_locked <= 1'b1;
        step;
        chk("xcvr_rx_reset", 1, xcvr_rx_reset);
        repeat (3) step;
        chk("xcvr_rx_reset", 0, xcvr_rx_reset);
        chk("xcvr_tx_reset", 0, xcvr_tx_reset);
        // Each reset cause, back to back; buffer state bit 0 alone is no error
        for (int i = 0; i < 4; i++) begin
            c = 3'b100 >> i;
            @(posedge clk);
            soft_reset <= c[2];
            xcvr_rx_buf_state <= {c[1], 1'b1};
            xcvr_tx_buf_err <= c[0];
            step;
            chk("xcvr_rx_reset", c[2] | c[1], xcvr_rx_reset);
            chk("xcvr_tx_reset", c[2] | c[0], xcvr_tx_reset);
        end
        @(posedge clk);
        clk_locked <= 1'b0;
        repeat (4) step;
        chk("xcvr_rx_reset", 1, xcvr_rx_reset);
        chk("xcvr_tx_reset", 1, xcvr_tx_reset);
        @(posedge clk);
        clk_locked <= 1'b1;
        repeat (4) step;
        $display("test resets done");
        // Control and character copies with every bit toggled
        for (int i = 0; i < 3; i++) begin
            pat = i[0] ? 32'h5A5A_5A5A : 32'hA5A5_A5A5;
            @(posedge clk);
            {power_down_req, tx_char, tx_is_ctrl, tx_disp_force, tx_disp_value} <= pat[11:0];
            {xcvr_rx_char, xcvr_rx_is_ctrl, xcvr_rx_is_comma, xcvr_rx_disp_err, xcvr_rx_not_in_table,
                xcvr_rx_run_disp, xcvr_rx_buf_state, xcvr_rx_clk_cor_cnt} <= pat[17:0];
            loss_of_sync <= pat[0];
            loopback_req <= pat[1];
            step;
            chk("tx copy", pat[11:0], {xcvr_power_down, xcvr_tx_char, xcvr_tx_is_ctrl, xcvr_tx_disp_mode,
                xcvr_tx_disp_val});
            chk("rx copy", pat[17:0], {rx_char, rx_is_ctrl, rx_is_comma, rx_disp_err, rx_not_in_table,
                rx_run_disp, rx_buf_state, rx_clk_cor_cnt});
            chk("align", {2{pat[0]}}, {plus_comma_align_en, minus_comma_align_en});
            chk("tbi_comma_detect_en", pat[0], tbi_comma_detect_en);
            chk("tbi_loopback", pat[1], tbi_loopback);
            chk("tbi_lock_ref", 0, tbi_lock_ref);
        end
        // Clock enable low freezes the copies
        @(posedge clk);
        ce <= 1'b0;
        tx_char <= 8'h3C;
        repeat (2) step;
        chk("xcvr_tx_char", pat[10:3], xcvr_tx_char);
        @(posedge clk);
        ce <= 1'b1;
        step;
        chk("xcvr_tx_char", 8'h3C, xcvr_tx_char);
        // One new code group every cycle
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            tx_symbol <= 10'(i * 93 + 5);
            #1;
            if (i > 0) chk("tbi_tx_symbol", 10'((i - 1) * 93 + 5), tbi_tx_symbol);
        end
        $display("test copies done");
        // Merged stream in order with a ready sink
        @(posedge clk);
        rx_sym_ready <= 1'b1;
        stream(10'h0C0, 3);
        chk("words", 6, got.size());
        for (int i = 0; i < 6; i++) chk("word", 10'h0C0 + i, got[i]);
        // Stalled sink: two words kept, the other four dropped
        @(posedge clk);
        rx_sym_ready <= 1'b0;
        got.delete();
        drops = 0;
        stream(10'h200, 3);
        chk("drops", 4, drops);
        chk("rx_sym_valid", 1, rx_sym_valid);
        chk("rx_sym_data", 10'h200, rx_sym_data);
        @(posedge clk);
        rx_sym_ready <= 1'b1;
        repeat (4) step;
        stream(10'h310, 1);
        chk("words", 4, got.size());
        chk("word", 10'h200, got[0]);
        chk("word", 10'h201, got[1]);
        chk("word", 10'h310, got[2]);
        chk("word", 10'h311, got[3]);
        $display("test stream done");
        end_sim;
    end
endmodule
